//--- design/bridge_ctl_pkg.sv
// Constants for the upper half of the bridge control register
package bridge_ctl_pkg;
  // ----------------------------------------------------------------
  // Configuration access
  // ----------------------------------------------------------------
  localparam logic [5:0] BRIDGE_CONTROL_DWORD = 6'h0f;
  localparam logic [31:0] BRIDGE_CONTROL_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int VGA_EN_BIT = 19;
  localparam int RSVD_20_BIT = 20;
  localparam int MA_MODE_BIT = 21;
  localparam int SEC_RESET_BIT = 22;
  localparam int FAST_B2B_BIT = 23;
  localparam int P_TO_SEL_BIT = 24;
  localparam int S_TO_SEL_BIT = 25;
  localparam int TO_STATUS_BIT = 26;
  localparam int TO_SERR_EN_BIT = 27;
  localparam logic [31:0] WRITE_MASK = 32'h0b68_0000;
  // ----------------------------------------------------------------
  // Legacy video decode and master abort read data
  // ----------------------------------------------------------------
  localparam logic [14:0] VGA_MEM_TOP = 15'h0005;
  localparam logic [9:0] VGA_IO_A_LO = 10'h3b0;
  localparam logic [9:0] VGA_IO_A_HI = 10'h3bb;
  localparam logic [9:0] VGA_IO_B_LO = 10'h3c0;
  localparam logic [9:0] VGA_IO_B_HI = 10'h3df;
  localparam logic [31:0] ABORT_READ_DATA = 32'hffff_ffff;
  // ----------------------------------------------------------------
  // Master time-out lengths in PCI clock cycles
  // ----------------------------------------------------------------
  localparam int TO_CNT_W = 16;
  localparam int TO_LONG_CYCLES = 32768;
  localparam int TO_SHORT_CYCLES = 1024;
endpackage

//--- design/bridge_ctl_upper.sv
// Upper half of the bridge control register and the logic its fields steer
// Summary of operation
// - VGA off: primary VGA cycles ignored unless in I/O window with ISA mode 0.
// - VGA on: claim memory 0xA0000-0xBFFFF downstream when memory enabled, regardless of windows or ISA mode.
// - VGA on: claim I/O 3B0-3BB, 3C0-3DF when I/O enabled, bits 15:10 ignored, upper 16 zero.
// - VGA on: secondary-bus VGA memory and I/O cycles are never claimed.
// - Abort mode 0: delayed cycles end with ready, reads all ones, posted no error.
// - Abort mode 1: delayed cycles get target abort; posted raises error if enabled.
// - Secondary reset bit drives the secondary reset output directly.
// - Secondary reset clears secondary time-out and claims, not primary or registers.
// - Fast back-to-back bit reads zero; never generated on secondary bus.
// - Primary time-out bit: 0 gives 2^15 cycles, 1 gives 2^10.
// - Counter starts with completion at queue head; expiry discards the transaction.
// - Secondary time-out bit uses the same encoding as the primary one.
// - Time-out status sets on discard; write 1 clears, write 0 keeps.
// - Time-out error enable plus command error enable raises error on discard.
// - Bits 20 and 31:28 are read-only zero.
`timescale 1ns/1ps
module bridge_ctl_upper #(
  parameter int TO_LONG = bridge_ctl_pkg::TO_LONG_CYCLES,
  parameter int TO_SHORT = bridge_ctl_pkg::TO_SHORT_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [5:0] cfg_dword,
  input wire logic [3:0] cfg_be_n,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic cmd_io_en,
  input wire logic cmd_mem_en,
  input wire logic cmd_serr_en,
  input wire logic isa_mode,
  input wire logic p_dec_valid,
  input wire logic p_dec_io,
  input wire logic [31:0] p_dec_addr,
  input wire logic p_window_hit,
  output logic p_claim,
  input wire logic s_dec_valid,
  input wire logic s_dec_io,
  input wire logic [31:0] s_dec_addr,
  input wire logic s_window_hit,
  output logic s_claim,
  input wire logic ma_event,
  input wire logic ma_delayed,
  input wire logic ma_read,
  output logic ma_ready,
  output logic ma_target_abort,
  output logic [31:0] ma_rdata,
  input wire logic p_dtc_head,
  input wire logic p_retry,
  output logic p_discard,
  input wire logic s_dtc_head,
  input wire logic s_retry,
  output logic s_discard,
  output logic sec_reset_out,
  output logic sec_fast_b2b,
  output logic primary_system_error_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] rdata;
    logic rvalid;
    logic p_claim;
    logic s_claim;
    logic ma_ready;
    logic ma_tabort;
    logic [31:0] ma_rdata;
    logic [bridge_ctl_pkg::TO_CNT_W-1:0] p_cnt;
    logic p_done;
    logic p_discard;
    logic [bridge_ctl_pkg::TO_CNT_W-1:0] s_cnt;
    logic s_done;
    logic s_discard;
    logic serr;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  localparam logic [bridge_ctl_pkg::TO_CNT_W:0] LONG_LAST =
    (bridge_ctl_pkg::TO_CNT_W+1)'(TO_LONG - 1);
  localparam logic [bridge_ctl_pkg::TO_CNT_W:0] SHORT_LAST =
    (bridge_ctl_pkg::TO_CNT_W+1)'(TO_SHORT - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic vga_hit(input logic io, input logic [31:0] a);
    logic [9:0] lo;
    lo = a[9:0];
    if (io) begin
      vga_hit = (a[31:16] == 16'h0000) &&
        (((lo >= bridge_ctl_pkg::VGA_IO_A_LO) && (lo <= bridge_ctl_pkg::VGA_IO_A_HI)) ||
         ((lo >= bridge_ctl_pkg::VGA_IO_B_LO) && (lo <= bridge_ctl_pkg::VGA_IO_B_HI)));
    end else begin
      vga_hit = (a[31:17] == bridge_ctl_pkg::VGA_MEM_TOP);
    end
  endfunction

  // Returns {expire, next count}; a finished wait idles until the head drops or a retry arrives
  function automatic logic [bridge_ctl_pkg::TO_CNT_W:0] to_step(
    input logic [bridge_ctl_pkg::TO_CNT_W-1:0] cnt,
    input logic head,
    input logic retry,
    input logic done,
    input logic short_sel
  );
    logic [bridge_ctl_pkg::TO_CNT_W:0] last;
    last = short_sel ? SHORT_LAST : LONG_LAST;
    if (!head || retry || done) begin
      to_step = '0;
    end else if ({1'b0, cnt} == last) begin
      to_step = {1'b1, {bridge_ctl_pkg::TO_CNT_W{1'b0}}};
    end else begin
      to_step = {1'b0, cnt + 1'b1};
    end
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [31:0] wmask;
  logic [31:0] rd_view;
  logic hit_cfg;
  logic p_vga;
  logic s_vga;
  logic vga_on;
  logic [bridge_ctl_pkg::TO_CNT_W:0] p_step;
  logic [bridge_ctl_pkg::TO_CNT_W:0] s_step;
  logic to_evt;

  always_comb begin
    nxt_state = state_ff;
    hit_cfg = (cfg_dword == bridge_ctl_pkg::BRIDGE_CONTROL_DWORD);
    wmask = {{8{~cfg_be_n[3]}}, {8{~cfg_be_n[2]}}, 16'h0000} & bridge_ctl_pkg::WRITE_MASK;
    vga_on = state_ff.ctl[bridge_ctl_pkg::VGA_EN_BIT];
    // Register writes; reserved and fast back-to-back bits never store
    if (cfg_wr && hit_cfg) begin
      nxt_state.ctl = (state_ff.ctl & ~wmask) | (cfg_wdata & wmask);
    end
    // Read view: lower half belongs elsewhere, reserved bits zero
    rd_view = state_ff.ctl & bridge_ctl_pkg::WRITE_MASK;
    rd_view[bridge_ctl_pkg::FAST_B2B_BIT] = 1'b0;
    rd_view[bridge_ctl_pkg::TO_STATUS_BIT] = state_ff.ctl[bridge_ctl_pkg::TO_STATUS_BIT];
    nxt_state.rvalid = cfg_rd;
    nxt_state.rdata = (cfg_rd && hit_cfg) ? rd_view : 32'h0000_0000;

    // Primary decode
    p_vga = vga_hit(p_dec_io, p_dec_addr);
    if (!p_dec_valid) begin
      nxt_state.p_claim = 1'b0;
    end else if (p_vga && vga_on) begin
      nxt_state.p_claim = p_dec_io ? cmd_io_en : cmd_mem_en;
    end else if (p_vga) begin
      nxt_state.p_claim = p_dec_io && p_window_hit && !isa_mode;
    end else begin
      nxt_state.p_claim = p_window_hit;
    end

    // Secondary decode, dead while the secondary side is in reset
    s_vga = vga_hit(s_dec_io, s_dec_addr);
    nxt_state.s_claim = s_dec_valid && s_window_hit && !(vga_on && s_vga) &&
      !state_ff.ctl[bridge_ctl_pkg::SEC_RESET_BIT];

    // Master abort completion
    nxt_state.ma_ready = 1'b0;
    nxt_state.ma_tabort = 1'b0;
    nxt_state.ma_rdata = 32'h0000_0000;
    nxt_state.serr = 1'b0;
    if (ma_event && ma_delayed) begin
      if (state_ff.ctl[bridge_ctl_pkg::MA_MODE_BIT]) begin
        nxt_state.ma_tabort = 1'b1;
      end else begin
        nxt_state.ma_ready = 1'b1;
        nxt_state.ma_rdata = ma_read ? bridge_ctl_pkg::ABORT_READ_DATA : 32'h0000_0000;
      end
    end
    if (ma_event && !ma_delayed && state_ff.ctl[bridge_ctl_pkg::MA_MODE_BIT] &&
        cmd_serr_en) begin
      nxt_state.serr = 1'b1;
    end

    // Delayed completion time-outs
    p_step = to_step(state_ff.p_cnt, p_dtc_head, p_retry, state_ff.p_done,
      state_ff.ctl[bridge_ctl_pkg::P_TO_SEL_BIT]);
    s_step = to_step(state_ff.s_cnt, s_dtc_head, s_retry, state_ff.s_done,
      state_ff.ctl[bridge_ctl_pkg::S_TO_SEL_BIT]);
    if (state_ff.ctl[bridge_ctl_pkg::SEC_RESET_BIT]) begin
      s_step = '0;
    end
    nxt_state.p_cnt = p_step[bridge_ctl_pkg::TO_CNT_W-1:0];
    nxt_state.s_cnt = s_step[bridge_ctl_pkg::TO_CNT_W-1:0];
    nxt_state.p_discard = p_step[bridge_ctl_pkg::TO_CNT_W];
    nxt_state.s_discard = s_step[bridge_ctl_pkg::TO_CNT_W];
    nxt_state.p_done = p_dtc_head && !p_retry && (state_ff.p_done || p_step[bridge_ctl_pkg::TO_CNT_W]);
    nxt_state.s_done = s_dtc_head && !s_retry && !state_ff.ctl[bridge_ctl_pkg::SEC_RESET_BIT] &&
      (state_ff.s_done || s_step[bridge_ctl_pkg::TO_CNT_W]);

    // Status: write 1 clears, a discard in the same cycle wins
    to_evt = state_ff.p_discard || state_ff.s_discard;
    if (cfg_wr && hit_cfg && !cfg_be_n[3] && cfg_wdata[bridge_ctl_pkg::TO_STATUS_BIT]) begin
      nxt_state.ctl[bridge_ctl_pkg::TO_STATUS_BIT] = 1'b0;
    end
    if (to_evt) begin
      nxt_state.ctl[bridge_ctl_pkg::TO_STATUS_BIT] = 1'b1;
      if (state_ff.ctl[bridge_ctl_pkg::TO_SERR_EN_BIT] && cmd_serr_en) begin
        nxt_state.serr = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_rdata = state_ff.rdata;
  assign cfg_rvalid = state_ff.rvalid;
  assign p_claim = state_ff.p_claim;
  assign s_claim = state_ff.s_claim;
  assign ma_ready = state_ff.ma_ready;
  assign ma_target_abort = state_ff.ma_tabort;
  assign ma_rdata = state_ff.ma_rdata;
  assign p_discard = state_ff.p_discard;
  assign s_discard = state_ff.s_discard;
  assign sec_reset_out = state_ff.ctl[bridge_ctl_pkg::SEC_RESET_BIT];
  assign sec_fast_b2b = state_ff.ctl[bridge_ctl_pkg::FAST_B2B_BIT];
  assign primary_system_error_out = state_ff.serr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_vga_mem;
    @(posedge clock) disable iff (rst)
    (p_dec_valid && !p_dec_io && p_dec_addr[31:17] == 15'h0005 && cmd_mem_en &&
     state_ff.ctl[19]) |=> p_claim;
  endproperty
  a_vga_mem: assert property (p_vga_mem) else $error("vga memory not claimed");

  property p_vga_off;
    @(posedge clock) disable iff (rst)
    (p_dec_valid && !p_dec_io && p_dec_addr[31:17] == 15'h0005 && !state_ff.ctl[19])
      |=> !p_claim;
  endproperty
  a_vga_off: assert property (p_vga_off) else $error("vga memory claimed while off");

  property p_sec_vga;
    @(posedge clock) disable iff (rst)
    (s_dec_valid && s_dec_io && s_dec_addr == 32'h0000_03c4 && state_ff.ctl[19]) |=> !s_claim;
  endproperty
  a_sec_vga: assert property (p_sec_vga) else $error("secondary vga claimed");

  property p_ma_normal;
    @(posedge clock) disable iff (rst)
    (ma_event && ma_delayed && ma_read && !state_ff.ctl[21]) |=>
      (ma_ready && !ma_target_abort && ma_rdata == 32'hffff_ffff);
  endproperty
  a_ma_normal: assert property (p_ma_normal) else $error("abort read not all ones");

  property p_ma_abort;
    @(posedge clock) disable iff (rst)
    (ma_event && ma_delayed && state_ff.ctl[21]) |=> (ma_target_abort && !ma_ready);
  endproperty
  a_ma_abort: assert property (p_ma_abort) else $error("no target abort");

  property p_sec_rst;
    @(posedge clock) disable iff (rst)
    (cfg_wr && cfg_dword == 6'h0f && !cfg_be_n[2]) |=> (sec_reset_out == $past(cfg_wdata[22]));
  endproperty
  a_sec_rst: assert property (p_sec_rst) else $error("secondary reset not following bit");

  property p_sec_quiet;
    @(posedge clock) disable iff (rst)
    (sec_reset_out && $past(sec_reset_out)) |-> (!s_discard && !s_claim);
  endproperty
  a_sec_quiet: assert property (p_sec_quiet) else $error("secondary active in reset");

  property p_rsvd;
    @(posedge clock) disable iff (rst)
    cfg_rvalid |-> (cfg_rdata[31:28] == 4'h0 && !cfg_rdata[20] && !cfg_rdata[23] && !sec_fast_b2b);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

  property p_status;
    @(posedge clock) disable iff (rst)
    (p_discard || s_discard) |=> state_ff.ctl[26];
  endproperty
  a_status: assert property (p_status) else $error("status not set on discard");

  property p_serr_to;
    @(posedge clock) disable iff (rst)
    ((p_discard || s_discard) && state_ff.ctl[27] && cmd_serr_en) |=> primary_system_error_out;
  endproperty
  a_serr_to: assert property (p_serr_to) else $error("no error on time-out");

  property p_no_serr;
    @(posedge clock) disable iff (rst)
    (!p_discard && !s_discard && !(ma_event && !ma_delayed)) |=> !primary_system_error_out;
  endproperty
  a_no_serr: assert property (p_no_serr) else $error("spurious system error");

  property p_retry_clr;
    @(posedge clock) disable iff (rst)
    (p_retry || !p_dtc_head) |=> (state_ff.p_cnt == 16'h0000 && !p_discard);
  endproperty
  a_retry_clr: assert property (p_retry_clr) else $error("counter not cleared");
endmodule

//--- test/retry_agent.sv
// Waiting initiator that repeats its delayed request after a set wait
`timescale 1ns/1ps
module retry_agent (
  input wire logic clock,
  input wire logic rst,
  input wire logic head,
  input wire logic enable,
  input wire logic [7:0] wait_cycles,
  output logic retry
);
  logic [7:0] cnt_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= 8'h00;
      retry <= 1'b0;
    end else begin
      retry <= 1'b0;
      if (!head || !enable) begin
        cnt_ff <= 8'h00;
      end else if (cnt_ff == wait_cycles) begin
        cnt_ff <= 8'h00;
        retry <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule

//--- test/bridge_ctl_upper_test.sv
// Self-checking bench for the bridge control upper half
`timescale 1ns/1ps
module bridge_ctl_upper_test;
  localparam int N_LONG = 64;
  localparam int N_SHORT = 16;
  logic clock, rst, cfg_wr, cfg_rd, cfg_rvalid, cmd_io_en, cmd_mem_en, cmd_serr_en, isa_mode;
  logic p_dec_valid, p_dec_io, p_window_hit, p_claim, s_dec_valid, s_dec_io, s_window_hit;
  logic s_claim, ma_event, ma_delayed, ma_read, ma_ready, ma_target_abort, p_dtc_head, p_retry;
  logic p_discard, s_dtc_head, s_retry, s_discard, sec_reset_out, sec_fast_b2b, agent_en;
  logic primary_system_error_out;
  logic [5:0] cfg_dword;
  logic [3:0] cfg_be_n;
  logic [7:0] agent_wait;
  logic [31:0] cfg_wdata, cfg_rdata, p_dec_addr, s_dec_addr, ma_rdata;
  logic [32:0] vtab [12] = '{33'h0_000a_0000, 33'h0_000b_ffff, 33'h0_000c_0000, 33'h0_0009_ffff,
    33'h1_0000_03b0, 33'h1_0000_03bb, 33'h1_0000_03bc, 33'h1_0000_03c0, 33'h1_0000_03df,
    33'h1_0000_03e0, 33'h1_0000_f7b0, 33'h1_0001_03b0};
  logic [11:0] vexp = 12'b0101_1011_0011;
  int failures, samples_checked, cycles, serr_cnt, disc_cnt, d;
  bridge_ctl_upper #(.TO_LONG(N_LONG), .TO_SHORT(N_SHORT)) i_bridge_ctl_upper (.clock, .rst,
    .cfg_wr, .cfg_rd, .cfg_dword, .cfg_be_n, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .cmd_io_en,
    .cmd_mem_en, .cmd_serr_en, .isa_mode, .p_dec_valid, .p_dec_io, .p_dec_addr, .p_window_hit,
    .p_claim, .s_dec_valid, .s_dec_io, .s_dec_addr, .s_window_hit, .s_claim, .ma_event,
    .ma_delayed, .ma_read, .ma_ready, .ma_target_abort, .ma_rdata, .p_dtc_head, .p_retry,
    .p_discard, .s_dtc_head, .s_retry, .s_discard, .sec_reset_out, .sec_fast_b2b,
    .primary_system_error_out);
  retry_agent i_retry_agent_p (.clock, .rst, .head(p_dtc_head), .enable(agent_en),
    .wait_cycles(agent_wait), .retry(p_retry));
  retry_agent i_retry_agent_s (.clock, .rst, .head(s_dtc_head), .enable(agent_en),
    .wait_cycles(agent_wait), .retry(s_retry));
  // ----------------------------------------------------------------
  // Clock, watchdog and event counters
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
    if (primary_system_error_out === 1'b1) serr_cnt++;
    if (p_discard === 1'b1 || s_discard === 1'b1) disc_cnt++;
  end
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [3:0] be_n, input logic [31:0] data);
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_dword <= 6'h0f;
    cfg_be_n <= be_n;
    cfg_wdata <= data;
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask
  task rdc(input logic [5:0] dword, input logic [31:0] exp);
    @(posedge clock);
    cfg_rd <= 1'b1;
    cfg_dword <= dword;
    @(posedge clock);
    cfg_rd <= 1'b0;
    #1;
    chk("cfg_rvalid", 32'h1, {31'h0, cfg_rvalid});
    chk("cfg_rdata", exp, cfg_rdata);
  endtask
  task dec(input logic io, input logic [31:0] a, input logic ph, input logic sh,
    input logic ep);
    @(posedge clock);
    {p_dec_valid, s_dec_valid, p_dec_io, s_dec_io} <= {2'b11, io, io};
    {p_dec_addr, s_dec_addr, p_window_hit, s_window_hit} <= {a, a, ph, sh};
    @(posedge clock);
    {p_dec_valid, s_dec_valid} <= 2'b00;
    #1;
    chk("p_claim", {31'h0, ep}, {31'h0, p_claim});
    chk("s_claim", 32'h0, {31'h0, s_claim});
  endtask
  task ma(input logic dl, input logic rd, input logic [1:0] er, input logic [31:0] ed,
    input int es);
    d = serr_cnt;
    @(posedge clock);
    {ma_event, ma_delayed, ma_read} <= {1'b1, dl, rd};
    @(posedge clock);
    ma_event <= 1'b0;
    #1;
    if (dl) chk("ma_ready_abort", {30'h0, er}, {30'h0, ma_ready, ma_target_abort});
    chk("ma_rdata", ed, ma_rdata);
    @(posedge clock);
    #1;
    chk("serr_pulses", es, serr_cnt - d);
  endtask
  task tmo(input logic side, input int en, input logic [31:0] ereg, input int es);
    int n;
    n = 0;
    d = serr_cnt;
    @(posedge clock);
    if (side) s_dtc_head <= 1'b1;
    else p_dtc_head <= 1'b1;
    while (n < 200 && (side ? s_discard : p_discard) !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("discard_delay", en, n);
    @(posedge clock);
    {p_dtc_head, s_dtc_head} <= 2'b00;
    rdc(6'h0f, ereg);
    chk("serr_pulses", es, serr_cnt - d);
  endtask
  task finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, cfg_wr, cfg_rd, cfg_dword, cfg_be_n, cfg_wdata} = {1'b1, 44'h0};
    {cmd_io_en, cmd_mem_en, cmd_serr_en, isa_mode, p_dec_valid, p_dec_io} = 6'b111000;
    {p_window_hit, s_dec_valid, s_dec_io, s_window_hit, ma_event, ma_delayed} = 6'h0;
    {p_dec_addr, s_dec_addr, ma_read, p_dtc_head, s_dtc_head, agent_en} = 68'h0;
    agent_wait = 8'h08;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rdc(6'h0f, 32'h0);
    wr(4'h0, 32'hffff_ffff);
    rdc(6'h0f, 32'h0b68_0000);
    rdc(6'h10, 32'h0);
    chk("sec_reset_out", 32'h1, {31'h0, sec_reset_out});
    chk("sec_fast_b2b", 32'h0, {31'h0, sec_fast_b2b});
    d = disc_cnt;
    s_dtc_head <= 1'b1;
    repeat (40) @(posedge clock);
    s_dtc_head <= 1'b0;
    chk("sec_discards", 32'h0, disc_cnt - d);
    dec(1'b0, 32'h000a_0000, 1'b0, 1'b1, 1'b1);
    wr(4'hb, 32'h0);
    rdc(6'h0f, 32'h0b00_0000);
    chk("sec_reset_out", 32'h0, {31'h0, sec_reset_out});
    $display("registers done");
    wr(4'h3, 32'h0008_0000);
    for (int i = 0; i < 12; i++) dec(vtab[i][32], vtab[i][31:0], 1'b0, vexp[i], vexp[i]);
    cmd_mem_en <= 1'b0;
    dec(1'b0, 32'h000a_0000, 1'b0, 1'b0, 1'b0);
    cmd_mem_en <= 1'b1;
    wr(4'h3, 32'h0);
    dec(1'b0, 32'h000a_0000, 1'b0, 1'b0, 1'b0);
    dec(1'b1, 32'h0000_03c0, 1'b1, 1'b0, 1'b1);
    $display("decode done");
    ma(1'b1, 1'b1, 2'b10, 32'hffff_ffff, 0);
    ma(1'b1, 1'b0, 2'b10, 32'h0, 0);
    ma(1'b0, 1'b0, 2'b00, 32'h0, 0);
    wr(4'h3, 32'h0020_0000);
    ma(1'b1, 1'b1, 2'b01, 32'h0, 0);
    ma(1'b0, 1'b0, 2'b00, 32'h0, 1);
    cmd_serr_en <= 1'b0;
    ma(1'b0, 1'b0, 2'b00, 32'h0, 0);
    cmd_serr_en <= 1'b1;
    $display("master abort done");
    wr(4'h3, 32'h0900_0000);
    tmo(1'b0, N_SHORT, 32'h0d00_0000, 1);
    wr(4'hb, 32'h0400_0000);
    rdc(6'h0f, 32'h0d00_0000);
    wr(4'h3, 32'h0);
    rdc(6'h0f, 32'h0400_0000);
    wr(4'h7, 32'h0400_0000);
    rdc(6'h0f, 32'h0);
    tmo(1'b1, N_LONG, 32'h0400_0000, 0);
    cmd_serr_en <= 1'b0;
    wr(4'h7, 32'h0e00_0000);
    tmo(1'b1, N_SHORT, 32'h0e00_0000, 0);
    cmd_serr_en <= 1'b1;
    wr(4'h7, 32'h0400_0000);
    tmo(1'b0, N_LONG, 32'h0400_0000, 0);
    $display("time-out done");
    d = disc_cnt;
    {agent_en, p_dtc_head, s_dtc_head} <= 3'b111;
    repeat (150) @(posedge clock);
    {agent_en, p_dtc_head, s_dtc_head} <= 3'b000;
    chk("retried_discards", 32'h0, disc_cnt - d);
    $display("retry done");
    finish_test();
  end
endmodule
